// [dv/sbat_agent.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// controller model on the far side of the processor bus
module sbat_agent (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [31:0] addr_data_out,
    input  wire logic [4:0]  cmd_id_out,
    input  wire logic        cpu_valid_n,
    input  wire logic        cpu_owns_bus_n,
    input  wire logic        kill,     // refuse commands
    input  wire logic        hold_req, // want the bus
    input  wire logic        resp_err, // flag the answer
    input  wire logic        xw_go,    // start an external write
    input  wire logic [31:0] xw_data,
    output var  logic        ext_valid_n,
    output var  logic        ext_accept_n,
    output var  logic        ext_bus_request_n,
    output var  logic [31:0] agent_ad,
    output var  logic [4:0]  agent_cmd,
    output var  logic [15:0] wr_cnt,   // data words taken
    output var  logic [15:0] eob_cnt,  // end tags taken
    output var  logic [31:0] wr_last
);
    logic        acc_prev_n; // accept one cycle back
    logic        ign_q;      // data cycle after a killed write
    logic        pend_q;     // read issued, answer owed
    logic [1:0]  st_q;       // own transfer step
    logic [31:0] rd_addr;    // address of the issued read
    wire         cmd_cyc = !cpu_valid_n && !cmd_id_out[4];
    // ====================================================================
    // everything the agent drives
    always @(posedge clk_sys) begin
        ext_accept_n <= kill;
        acc_prev_n <= ext_accept_n;
        ign_q <= cmd_cyc && ext_accept_n && !acc_prev_n;
        ext_bus_request_n <= !hold_req;
        ext_valid_n <= 1'b1;
        agent_ad <= ~agent_ad; // released bus never keeps a stale word
        agent_cmd <= ~agent_cmd;
        if (!cpu_valid_n && cmd_id_out[4] && !ign_q) begin
            wr_cnt <= wr_cnt + 16'h0001;
            eob_cnt <= eob_cnt + {15'h0000, cmd_id_out[0]};
            wr_last <= addr_data_out;
        end
        if (cmd_cyc && cmd_id_out[3:0] == 4'h1 && !ext_accept_n && !acc_prev_n) begin
            pend_q <= 1'b1;
            rd_addr <= addr_data_out;
        end
        case (st_q)
            2'h0: if (cpu_owns_bus_n && xw_go) begin
                ext_valid_n <= 1'b0;
                agent_cmd <= 5'h02;
                agent_ad <= ~xw_data;
                st_q <= 2'h1;
            end else if (cpu_owns_bus_n && pend_q) begin
                st_q <= 2'h2;
            end
            2'h1: begin
                ext_valid_n <= 1'b0;
                agent_cmd <= 5'h11;
                agent_ad <= xw_data;
                st_q <= 2'h0;
            end
            2'h2: st_q <= 2'h3;
            default: begin
                ext_valid_n <= 1'b0;
                agent_cmd <= {3'h4, resp_err, 1'b1};
                agent_ad <= ~rd_addr;
                pend_q <= 1'b0;
                st_q <= 2'h0;
            end
        endcase
        if (sys_rst) begin
            ext_bus_request_n <= 1'b1;
            ext_valid_n <= 1'b1;
            {ign_q, pend_q, st_q, wr_cnt, eob_cnt, agent_ad, agent_cmd} <= '0;
        end
    end
endmodule // sbat_agent
`default_nettype wire

// [dv/sbat_bus_if_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// protocol checker on the processor bus port
module sbat_bus_if_checker (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        power_on_reset_n,
    input wire logic [31:0] addr_data_in,
    input wire logic [4:0]  cmd_id_in,
    input wire logic [4:0]  cmd_id_out,
    input wire logic        addr_data_oe,
    input wire logic        cmd_id_oe,
    input wire logic        cpu_owns_bus_n,
    input wire logic        cpu_valid_n,
    input wire logic        ext_valid_n,
    input wire logic        ext_bus_request_n,
    input wire logic        rd_done,
    input wire logic        bus_error_q,
    input wire logic [31:0] irq_state
);
    logic        rd_wait_q;                              // read out, answer not back
    logic [31:0] xw_q;                                   // last agent data word
    wire         any_rst = sys_rst || !power_on_reset_n; // either reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (any_rst);
    // ====================================================================
    // helper state: read pending and agent data
    always @(posedge clk_sys) begin
        if (any_rst) rd_wait_q <= 1'b0;
        else if (!cpu_valid_n && cmd_id_out == 5'h01) rd_wait_q <= 1'b1;
        else if (rd_done) rd_wait_q <= 1'b0;
        if (!ext_valid_n && cmd_id_in[4]) xw_q <= addr_data_in;
    end
    AST_OE_MASTER: assert property (
        addr_data_oe == !cpu_owns_bus_n && cmd_id_oe == addr_data_oe)
        else $error("bus drive does not follow ownership");
    AST_VALID_OWNER: assert property (
        !cpu_valid_n |-> !cpu_owns_bus_n && addr_data_oe)
        else $error("valid cycle while not owner");
    AST_RESET_MASTER: assert property (disable iff (1'b0)
        $past(any_rst) |-> !cpu_owns_bus_n && cpu_valid_n)
        else $error("not owner right after reset");
    AST_STAY_SLAVE: assert property (
        cpu_owns_bus_n && !ext_bus_request_n |=> cpu_owns_bus_n)
        else $error("bus taken back while agent requests");
    AST_TURNAROUND: assert property (
        $rose(ext_bus_request_n) && cpu_owns_bus_n && !rd_wait_q
        |=> cpu_owns_bus_n ##1 !cpu_owns_bus_n)
        else $error("retake not two cycles after request release");
    AST_RELEASE_REQ: assert property (
        $fell(ext_bus_request_n) && !cpu_owns_bus_n |-> ##[1:200] cpu_owns_bus_n)
        else $error("bus never released to requester");
    AST_ERR: assert property (
        !ext_valid_n && cpu_owns_bus_n && rd_wait_q && cmd_id_in[4] && cmd_id_in[1]
        |-> ##[1:3] bus_error_q)
        else $error("flagged answer gave no bus error");
    AST_IRQ: assert property (
        !ext_valid_n && cmd_id_in[4] && cpu_owns_bus_n && !rd_wait_q |-> ##[1:2] irq_state == xw_q)
        else $error("external write missed interrupt store");
endmodule // sbat_bus_if_checker
bind sbat_bus_if sbat_bus_if_checker u_chk (.clk_sys, .sys_rst, .power_on_reset_n,
    .addr_data_in, .cmd_id_in, .cmd_id_out, .addr_data_oe, .cmd_id_oe, .cpu_owns_bus_n,
    .cpu_valid_n, .ext_valid_n, .ext_bus_request_n, .rd_done, .bus_error_q, .irq_state);
`default_nettype wire

// [dv/test_sys_bus_arbitration_transactions.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// bench: processor bus port against the controller model
module test_sys_bus_arbitration_transactions;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, power_on_reset_n = 1'b1;
    logic        req_valid = 1'b0, req_is_read = 1'b0, rate_wxx = 1'b0, wr_valid = 1'b0;
    logic        kill = 1'b0, hold_req = 1'b0, resp_err = 1'b0, xw_go = 1'b0;
    logic [31:0] req_addr = 32'h0, wr_data = 32'h0, xw_data = 32'h0;
    logic [5:0]  req_bytes = 6'h01;
    wire  [31:0] addr_data_out, addr_data_in, agent_ad, irq_state, rd_data_q, wr_last;
    wire  [4:0]  cmd_id_out, cmd_id_in, agent_cmd;
    wire  [15:0] wr_cnt, eob_cnt;
    wire         addr_data_oe, cmd_id_oe, cpu_owns_bus_n, cpu_valid_n, ext_valid_n;
    wire         ext_accept_n, ext_bus_request_n, req_ready, wr_ready, rd_data_valid;
    wire         rd_done, bus_error_q;
    wire         agent_rst = sys_rst || !power_on_reset_n;
    int          err_count = 0, checked = 0;
    int          sizes[7] = '{1, 4, 5, 7, 8, 16, 63}; // byte counts at the boundaries
    // bus level: owner drives, otherwise the agent's pattern
    assign addr_data_in = addr_data_oe ? addr_data_out : agent_ad;
    assign cmd_id_in = cmd_id_oe ? cmd_id_out : agent_cmd;
    always #4 clk_sys = !clk_sys;
    sbat_bus_if dut (.clk_sys, .sys_rst, .power_on_reset_n, .addr_data_in, .addr_data_out,
        .addr_data_oe, .cmd_id_in, .cmd_id_out, .cmd_id_oe, .cpu_owns_bus_n, .cpu_valid_n,
        .ext_valid_n, .ext_accept_n, .ext_bus_request_n, .req_valid, .req_ready, .req_is_read,
        .req_addr, .req_bytes, .rate_wxx, .wr_valid, .wr_ready, .wr_data, .rd_data_valid,
        .rd_data_q, .rd_done, .bus_error_q, .irq_state);
    sbat_agent agent (.clk_sys, .sys_rst(agent_rst), .addr_data_out, .cmd_id_out,
        .cpu_valid_n, .cpu_owns_bus_n, .kill, .hold_req, .resp_err, .xw_go, .xw_data,
        .ext_valid_n, .ext_accept_n, .ext_bus_request_n, .agent_ad, .agent_cmd, .wr_cnt,
        .eob_cnt, .wr_last);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic int words(input int n); // data cycles of a write
        return (n + 3) / 4;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic send_req(input logic rd, input logic [31:0] a, input logic [5:0] n);
        @(posedge clk_sys);
        {req_valid, req_is_read, req_addr, req_bytes} <= {1'b1, rd, a, n};
        do @(negedge clk_sys); while (req_ready !== 1'b1);
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask
    // open accept for one cycle while a command stands: it is killed
    task automatic kill_once;
        do @(negedge clk_sys); while (cpu_valid_n !== 1'b0);
        @(posedge clk_sys) kill <= 1'b0;
        @(posedge clk_sys) kill <= 1'b1;
        repeat (3) @(posedge clk_sys);
        kill <= 1'b0;
    endtask
    task automatic do_write(input int n, input logic killit);
        logic [31:0] w;
        int c0;
        int e0;
        {c0, e0} = {16'h0, wr_cnt, 16'h0, eob_cnt};
        @(posedge clk_sys);
        kill <= killit;
        rate_wxx <= 1'($urandom_range(0, 1));
        fork
            begin
                @(posedge clk_sys);
                for (int k = 0; k < words(n); k++) begin
                    w = $urandom;
                    {wr_valid, wr_data} <= {1'b1, w};
                    do @(negedge clk_sys); while (wr_ready !== 1'b1);
                    @(posedge clk_sys);
                end
                wr_valid <= 1'b0;
            end
            send_req(1'b0, $urandom & 32'hffff_fffc, 6'(n));
            if (killit) kill_once;
        join
        for (int i = 0; i < 300 && wr_cnt != 16'(c0 + words(n)); i++) @(negedge clk_sys);
        check(wr_cnt - 16'(c0), words(n));
        check(wr_last, w);
        if (n > 7) check(eob_cnt - 16'(e0), 1);
    endtask
    task automatic do_read(input logic err, input logic hold, input logic killit);
        logic [31:0] a;
        a = $urandom & 32'hffff_fffc;
        @(posedge clk_sys);
        {kill, resp_err} <= {killit, err};
        fork
            send_req(1'b1, a, 6'h04);
            if (killit) kill_once;
        join
        for (int i = 0; i < 100 && cpu_owns_bus_n !== 1'b1; i++) @(negedge clk_sys);
        check(req_ready, 0);
        if (hold) @(posedge clk_sys) hold_req <= 1'b1;
        for (int i = 0; i < 200 && rd_done !== 1'b1; i++) @(negedge clk_sys);
        check(rd_data_valid, 1);
        check(rd_data_q, ~a);
        check(bus_error_q, err);
        repeat (4) @(negedge clk_sys);
        check(cpu_owns_bus_n, hold);
        @(posedge clk_sys) hold_req <= 1'b0;
        repeat (6) @(negedge clk_sys);
        check(cpu_owns_bus_n, 0);
    endtask
    // watchdog: about 17 transfers of some tens of cycles each
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        tally_and_finish;
    end
    initial begin
        logic [31:0] v;
        void'($urandom(32'hc0f5b810));
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys) check(cpu_owns_bus_n, 0);
        foreach (sizes[i]) do_write(sizes[i], i == 1);
        repeat (6) do_write($urandom_range(1, 63), 1'($urandom_range(0, 1)));
        do_read(1'b0, 1'b0, 1'b0);
        do_read(1'b1, 1'b0, 1'b1);
        do_read(1'b0, 1'b1, 1'b0);
        do_write(9, 1'b0);
        @(posedge clk_sys) hold_req <= 1'b1;
        for (int i = 0; i < 200 && cpu_owns_bus_n !== 1'b1; i++) @(negedge clk_sys);
        v = $urandom;
        @(posedge clk_sys) {xw_go, xw_data} <= {1'b1, v};
        @(posedge clk_sys) xw_go <= 1'b0;
        repeat (4) @(negedge clk_sys);
        check(irq_state, v);
        check(cpu_owns_bus_n, 1);
        @(posedge clk_sys) power_on_reset_n <= 1'b0;
        @(posedge clk_sys) {power_on_reset_n, hold_req} <= 2'b10;
        @(negedge clk_sys) check(cpu_owns_bus_n, 0);
        tally_and_finish;
    end
endmodule // test_sys_bus_arbitration_transactions
`default_nettype wire

// [rtl/sbat_buf2.v]
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// two-entry skid buffer for outgoing write words
module sbat_buf2 (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        in_valid,
    output wire        in_ready,
    input  wire [35:0] in_data,
    output wire        out_valid,
    input  wire        out_ready,
    output wire [35:0] out_data
);
    reg  [35:0] mem_q [0:1];   // storage
    reg         wp_q;          // write pointer
    reg         rp_q;          // read pointer
    reg  [1:0]  cnt_q;         // fill level

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];

    // pointer and level update
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (in_valid && in_ready) begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            if (out_valid && out_ready)
                rp_q <= ~rp_q;
            case ({in_valid && in_ready, out_valid && out_ready})
                2'b10:   cnt_q <= cnt_q + 2'h1;
                2'b01:   cnt_q <= cnt_q - 2'h1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // sbat_buf2
`default_nettype wire

// [rtl/sbat_bus_if.v]
// What this block does
// - cpu owns bus after reset by default
// - pending read: release, retake after end data
// - agent request at end keeps cpu slave
// - agent stays master while request held
// - retake bus two cycles after request drops
// - accept all agent cycles while slave
// - reset makes cpu master immediately
// - issued after accept two consecutive cycles
// - accept then drop kills command, retry
// - killed read: release, regain three later
// - write: command cycle then valid data cycles
// - up to four bytes one cycle, split 5-7
// - big writes four bytes, last tagged
// - data follows issue cycle at rate
// - only one read outstanding
// - release bus after read issue
// - external writes go to interrupts
// - any error response cycle raises bus error
// - command bit four marks data cycles
// - rates one word or word plus two idle
// - each valid cycle carries new values, except the command, which repeats each cycle until issued
`timescale 1ns/1ns
`default_nettype none
`include "sbat_map.vh"
module sbat_bus_if (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        power_on_reset_n,
    // shared bus
    input  wire [31:0] addr_data_in,
    output reg  [31:0] addr_data_out,
    output wire        addr_data_oe,
    input  wire [4:0]  cmd_id_in,
    output reg  [4:0]  cmd_id_out,
    output wire        cmd_id_oe,
    output wire        cpu_owns_bus_n,
    output wire        cpu_valid_n,
    input  wire        ext_valid_n,
    input  wire        ext_accept_n,
    input  wire        ext_bus_request_n,
    // cpu request side
    input  wire        req_valid,
    output wire        req_ready,
    input  wire        req_is_read,
    input  wire [31:0] req_addr,
    input  wire [5:0]  req_bytes,
    input  wire        rate_wxx,
    input  wire        wr_valid,
    output wire        wr_ready,
    input  wire [31:0] wr_data,
    output reg         rd_data_valid,
    output reg  [31:0] rd_data_q,
    output reg         rd_done,
    output reg         bus_error_q,
    output wire [31:0] irq_state
);
    // ================================================================
    // states
    localparam [2:0] ST_IDLE = 3'h0;   // master, nothing to do
    localparam [2:0] ST_ADDR = 3'h1;   // presenting command
    localparam [2:0] ST_DATA = 3'h2;   // sending write words
    localparam [2:0] ST_SLV  = 3'h3;   // slave
    localparam [2:0] ST_GAP  = 3'h4;   // turnaround before retake
    localparam [2:0] ST_KILL = 3'h5;   // one cycle after a killed read

    reg  [2:0]  st_q;          // state
    reg  [2:0]  st_d;
    reg         own_q;         // master indicator, active high
    reg         valid_q;       // drive valid this cycle
    reg         acc_q;         // accept seen last cycle
    reg         rd_pend_q;     // read outstanding
    reg  [1:0]  gap_q;         // turnaround counter
    reg  [1:0]  idle_q;        // wxx idle counter
    reg  [5:0]  left_q;        // bytes left in current transaction
    reg  [5:0]  rest_q;        // bytes for a following split transaction
    reg         is_rd_q;       // current command is a read
    reg         split_q;       // current transfer is a small split piece
    reg         ewr_q;         // external write address seen
    reg         cur_last_q;    // last-word flag, only written by reset, stays low
    reg         retry_q;       // command dropped unissued, present again
    reg  [31:0] addr_q;        // start address of the current write
    wire        req_n_ok;      // agent not requesting
    wire        rst_any;
    wire        issued;
    wire        killed;
    wire        ext_data;
    wire        buf_valid;
    wire [35:0] buf_data;
    wire        buf_take;
    wire [5:0]  first_len;

    assign rst_any  = sys_rst | ~power_on_reset_n;
    assign req_n_ok = ext_bus_request_n;
    assign issued   = (st_q == ST_ADDR) && acc_q && !ext_accept_n;
    assign killed   = (st_q == ST_ADDR) && acc_q && ext_accept_n;
    assign ext_data = !own_q && !ext_valid_n && cmd_id_in[`SBAT_CMD_DATA_BIT];
    assign cpu_owns_bus_n = ~own_q;
    assign cpu_valid_n    = ~valid_q;
    assign addr_data_oe   = own_q;
    assign cmd_id_oe      = own_q;
    assign req_ready = (st_q == ST_IDLE) && !rd_pend_q && req_n_ok;

    // ================================================================
    // first piece length: split 5..7 into four plus rest
    function [5:0] sbat_first;
        input [5:0] n;
        begin
            if (n > 6'd4 && n < 6'd8)
                sbat_first = 6'd4;
            else
                sbat_first = n;
        end
    endfunction
    assign first_len = sbat_first(req_bytes);

    // ================================================================
    // write word buffer, stalls the source when full
    sbat_buf2 u_buf (
        .clk_sys   (clk_sys),
        .sys_rst   (rst_any),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({4'h0, wr_data}),
        .out_valid (buf_valid),
        .out_ready (buf_take),
        .out_data  (buf_data)
    );
    // first word goes out right at the issue edge, so data follows the issue cycle
    assign buf_take = ((st_q == ST_DATA) || (issued && !is_rd_q)) && (idle_q == 2'h0)
                      && (left_q != 6'd0) && buf_valid;

    // ================================================================
    // interrupt store fed by external writes
    sbat_irq_regs u_irq (
        .clk_sys (clk_sys),
        .sys_rst (rst_any),
        .wr_en   (ext_data && ewr_q),
        .wr_data (addr_data_in),
        .irq_q   (irq_state)
    );

    // ================================================================
    // next state
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (!req_n_ok)
                    st_d = ST_SLV;
                else if (req_valid && !rd_pend_q)
                    st_d = ST_ADDR;
            end
            ST_ADDR: begin
                if (killed)
                    st_d = is_rd_q ? ST_KILL : ST_ADDR;
                else if (issued)
                    st_d = is_rd_q ? ST_SLV : ST_DATA;
                else if (!req_n_ok && ext_accept_n)
                    st_d = ST_SLV;
            end
            ST_DATA: begin
                // leave only after the last word and its idle cycles
                if (left_q == 6'd0 && idle_q == 2'h0)
                    st_d = (rest_q != 6'd0) ? ST_ADDR : ST_IDLE;
            end
            ST_KILL: st_d = ST_SLV;
            ST_SLV: begin
                if (req_n_ok && !rd_pend_q)
                    st_d = ST_GAP;
            end
            ST_GAP: begin
                if (!req_n_ok)
                    st_d = ST_SLV;
                // the edge that sees the release counts as the first turnaround cycle
                else if (gap_q == `SBAT_TURNAROUND - 2'h2)
                    st_d = retry_q ? ST_ADDR : ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // ================================================================
    // sequential control
    always @(posedge clk_sys) begin
        if (rst_any) begin
            st_q        <= ST_IDLE;
            own_q       <= 1'b1;
            valid_q     <= 1'b0;
            acc_q       <= 1'b0;
            rd_pend_q   <= 1'b0;
            gap_q       <= 2'h0;
            idle_q      <= 2'h0;
            left_q      <= 6'd0;
            rest_q      <= 6'd0;
            is_rd_q     <= 1'b0;
            split_q     <= 1'b0;
            ewr_q       <= 1'b0;
            cur_last_q  <= 1'b0;
            retry_q     <= 1'b0;
            addr_q      <= 32'h0;
            addr_data_out <= 32'h0;
            cmd_id_out  <= 5'h0;
            rd_data_valid <= 1'b0;
            rd_data_q   <= 32'h0;
            rd_done     <= 1'b0;
            bus_error_q <= 1'b0;
        end else begin
            st_q          <= st_d;
            acc_q         <= !ext_accept_n;
            rd_data_valid <= 1'b0;
            rd_done       <= 1'b0;
            valid_q       <= 1'b0;
            own_q         <= (st_d == ST_IDLE) || (st_d == ST_ADDR) || (st_d == ST_DATA);
            gap_q         <= (st_q == ST_GAP) ? gap_q + 2'h1 : 2'h0;
            // take a new request
            if (st_q == ST_IDLE && st_d == ST_ADDR) begin
                is_rd_q <= req_is_read;
                addr_data_out <= req_addr;
                addr_q  <= req_addr;
                left_q  <= req_is_read ? 6'd0 : first_len;
                rest_q  <= req_is_read ? 6'd0 : req_bytes - first_len;
                split_q <= 1'b0;
            end
            // continue a split write with the remainder
            if (st_q == ST_DATA && st_d == ST_ADDR) begin
                left_q  <= rest_q;
                rest_q  <= 6'd0;
                split_q <= 1'b1;
                addr_data_out <= addr_q + 32'h4;
            end
            // address cycle: repeat command each cycle
            if (st_d == ST_ADDR) begin
                valid_q    <= 1'b1;
                cmd_id_out <= {1'b0, (st_q == ST_IDLE ? req_is_read : is_rd_q)
                                     ? `SBAT_CMD_READ : `SBAT_CMD_WRITE};
            end
            if (issued && is_rd_q)
                rd_pend_q <= 1'b1;
            if (issued && !is_rd_q)
                idle_q <= 2'h0;
            // killed read or bus lost before issue: come back with the same command
            if (st_q == ST_ADDR && !issued && st_d != ST_ADDR)
                retry_q <= 1'b1;
            if (st_q == ST_GAP && st_d == ST_ADDR)
                retry_q <= 1'b0;
            // data cycles at programmed rate
            if (st_q == ST_DATA || buf_take) begin
                if (buf_take) begin
                    valid_q       <= 1'b1;
                    addr_data_out <= buf_data[31:0];
                    cmd_id_out    <= {1'b1, 3'h0, left_q <= `SBAT_BYTES_WORD};
                    left_q        <= (left_q > `SBAT_BYTES_WORD) ?
                                     left_q - `SBAT_BYTES_WORD : 6'd0;
                    idle_q        <= rate_wxx ? `SBAT_WXX_IDLE : 2'h0;
                end else if (idle_q != 2'h0)
                    idle_q <= idle_q - 2'h1;          // hold data
            end
            // external cycles while slave
            if (!own_q && !ext_valid_n) begin
                if (!cmd_id_in[`SBAT_CMD_DATA_BIT])
                    ewr_q <= (cmd_id_in[3:0] == `SBAT_CMD_WRITE);
                else if (ewr_q)
                    ewr_q <= 1'b0;
                else if (rd_pend_q) begin
                    rd_data_valid <= 1'b1;
                    rd_data_q     <= addr_data_in;
                    if (cmd_id_in[`SBAT_ID_ERR_BIT])
                        bus_error_q <= 1'b1;
                    if (cmd_id_in[`SBAT_ID_LAST_BIT]) begin
                        rd_pend_q <= 1'b0;
                        rd_done   <= 1'b1;
                    end
                end
            end
            if (req_valid && req_ready)
                bus_error_q <= 1'b0;
        end
    end

    // split and last flags drive no logic; the split address step comes from the state change
    wire unused_ok = split_q | cur_last_q | (|buf_data[35:32]);
endmodule // sbat_bus_if
`default_nettype wire

// [rtl/sbat_irq_regs.v]
`timescale 1ns/1ns
`default_nettype none
// ====================================================================
// interrupt input store: the only target of external writes
module sbat_irq_regs (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        wr_en,
    input  wire [31:0] wr_data,
    output reg  [31:0] irq_q
);
    // latch written word, address ignored
    always @(posedge clk_sys) begin
        if (sys_rst)
            irq_q <= 32'h0;
        else if (wr_en)
            irq_q <= wr_data;
    end
endmodule // sbat_irq_regs
`default_nettype wire

// [shared/sbat_map.vh]
`ifndef SBAT_MAP_VH
`define SBAT_MAP_VH
// ====================================================================
// command / data identifier encoding
`define SBAT_CMD_DATA_BIT   4
`define SBAT_CMD_READ       4'h1
`define SBAT_CMD_WRITE      4'h2
`define SBAT_ID_LAST_BIT    0
`define SBAT_ID_ERR_BIT     1
// ====================================================================
// timing counts
`define SBAT_TURNAROUND     2'h2
`define SBAT_WXX_IDLE       2'h2
`define SBAT_BYTES_WORD     4'h4
`define SBAT_BUF_DEPTH      2
`endif
